// ### rtl/timer_output_pin_init.sv
// Purpose: output pin init and mode transition control, 5 channels
// Assumes: waveform generation lives elsewhere; pins output only
// Notes:   all state is one struct; every output is a flop
//
// What this block does
// - six modes, each only on its channels
// - pins low in reset and standby
// - timer selected: pin shows present level
// - hardware cutoff on large-current pins
// - no pulse_mode_two/phase to/from compl/rsync moves
// - io control or output control sets level
// - pulse one: b and d not initialised
// - pulse two: cycle pin not initialised
// - normal/pulse_mode_two buffer pins not initialised
// - pulse one with buffer: c not initialised
// - compl/rsync level from phase selects
// - halted hi-z then rsync: stale output
// - mode resets to normal
// - standby cannot clear pending requests
// - simultaneous cascade capture not combined
//
// The register offsets and strobed register access were left to the implementer.
module timer_output_pin_init
(
  input  wire logic                                mclk_in,
  input  wire logic                                rstn_in,
  input  wire logic [timer_pin_pkg::AW-1:0]        addr_in,
  input  wire logic [timer_pin_pkg::DW-1:0]        wdata_in,
  input  wire logic                                wr_in,
  input  wire logic                                rd_in,
  input  wire logic [timer_pin_pkg::NCH-1:0]       irq_event_in,
  input  wire logic [1:0]                          capture_in,
  input  wire logic [15:0]                         ch1_count_in,
  input  wire logic [15:0]                         ch2_count_in,
  input  wire logic                                hw_cutoff_in,
  output logic      [timer_pin_pkg::DW-1:0]        rdata_out,
  output logic      [timer_pin_pkg::NCH-1:0]       irq_req_out,
  output logic      [timer_pin_pkg::NPIN-1:0]      pin_level_out,
  output logic      [timer_pin_pkg::NPIN-1:0]      pin_oe_out
);

  // ****************************************
  // helper functions
  // ****************************************

  // mode allowed on channel and from the present mode
  function automatic logic move_ok(input int ch,
                                   input timer_pin_pkg::mode_type from,
                                   input logic [2:0] to);
    logic ok;
    ok = 1'b0;
    case (to)
      timer_pin_pkg::MODE_NORMAL,
      timer_pin_pkg::MODE_PULSE1: ok = 1'b1;
      timer_pin_pkg::MODE_PULSE2: ok = (ch <= 2);
      timer_pin_pkg::MODE_PHASE:  ok = (ch == 1) || (ch == 2);
      timer_pin_pkg::MODE_COMPL,
      timer_pin_pkg::MODE_RSYNC:
        // pulse_mode_two or phase cannot move straight in
        ok = (ch >= 3) && from != timer_pin_pkg::MODE_PULSE2
             && from != timer_pin_pkg::MODE_PHASE;
      default: ok = 1'b0; // codes six and seven
    endcase
    // compl/rsync cannot move into pulse_mode_two or phase
    if ((from == timer_pin_pkg::MODE_COMPL ||
         from == timer_pin_pkg::MODE_RSYNC) &&
        (to == timer_pin_pkg::MODE_PULSE2 ||
         to == timer_pin_pkg::MODE_PHASE))
    begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // may an io control write initialise pin p in this mode
  function automatic logic init_ok(input timer_pin_pkg::mode_type m,
                                   input logic bfa,
                                   input logic bfb,
                                   input int p);
    logic buf_pin;
    logic ok;
    // c buffers a, d buffers b
    buf_pin = (p == timer_pin_pkg::PIN_C && bfa) ||
              (p == timer_pin_pkg::PIN_D && bfb);
    ok = 1'b0;
    case (m)
      timer_pin_pkg::MODE_NORMAL: ok = !buf_pin;
      timer_pin_pkg::MODE_PULSE1:
        // b/d carry no waveform; c blocked by any buffer
        ok = (p == timer_pin_pkg::PIN_A) ||
             (p == timer_pin_pkg::PIN_C && !(bfa || bfb));
      timer_pin_pkg::MODE_PULSE2:
        ok = (p != timer_pin_pkg::CYC_PIN) && !buf_pin;
      timer_pin_pkg::MODE_PHASE:  ok = 1'b1;
      default:                    ok = 1'b0; // output control owns pins
    endcase
    return ok;
  endfunction

  // ****************************************
  // state
  // ****************************************

  timer_pin_pkg::state_type s_r;   // registered state
  timer_pin_pkg::state_type s_nxt; // next state
  logic [timer_pin_pkg::NPIN-1:0] moe_mask; // pins enabled to output
  logic [3:0]                     nib;      // io nibble of a pin
  logic                           io_wr;    // io write hits this pin
  int                             idx;      // flat pin index

  // ****************************************
  // next state
  // ****************************************

  // one process builds the whole next state
  always_comb
  begin
    s_nxt = s_r;
    moe_mask = timer_pin_pkg::ALL_PINS;
    nib = 4'h0;
    io_wr = 1'b0;
    idx = 0;
    s_nxt.rdata = '0; // read data stands one cycle only

    // three-stage cutoff synchroniser, change when 2nd and 3rd agree
    s_nxt.sync = {s_r.sync[1:0], hw_cutoff_in};
    if (s_r.sync[2] == s_r.sync[1])
    begin
      s_nxt.cut = s_r.sync[2];
    end

    // sticky flags: clear first, so a same-cycle set wins
    if (wr_in && addr_in == timer_pin_pkg::STATUS)
    begin
      s_nxt.merr = s_r.merr & ~wdata_in[timer_pin_pkg::NCH-1:0];
      s_nxt.col = s_r.col & ~wdata_in[timer_pin_pkg::ST_COL];
      // in standby the request source cannot be cleared
      if (!s_r.stby)
      begin
        s_nxt.irq = s_r.irq &
          ~wdata_in[timer_pin_pkg::ST_IRQ +: timer_pin_pkg::NCH];
      end
    end
    s_nxt.irq = s_nxt.irq | irq_event_in;

    // shared registers, applied at the next edge
    if (wr_in)
    begin
      unique case (addr_in)
        timer_pin_pkg::OUTCTL: s_nxt.ols = wdata_in[1:0];
        timer_pin_pkg::MOE:    s_nxt.moe = wdata_in[5:0];
        timer_pin_pkg::CSTART:
          s_nxt.cst = wdata_in[timer_pin_pkg::NCH-1:0];
        timer_pin_pkg::PFSEL:
          s_nxt.pfs = wdata_in[timer_pin_pkg::NPIN-1:0];
        timer_pin_pkg::PDATA:
          s_nxt.pdat = wdata_in[timer_pin_pkg::NPIN-1:0];
        timer_pin_pkg::PDIR:
          s_nxt.pdir = wdata_in[timer_pin_pkg::NPIN-1:0];
        timer_pin_pkg::SYSCTL:
        begin
          s_nxt.stby = wdata_in[timer_pin_pkg::STBY_BIT];
          s_nxt.casc = wdata_in[timer_pin_pkg::CASC_BIT];
        end
        default: ; // per channel and read-only offsets
      endcase
    end

    // master enable gates the six channel 3/4 pins
    for (int k = 0; k < 6; k++)
    begin
      moe_mask[timer_pin_pkg::MOE_PIN[k]] = s_nxt.moe[k];
    end

    for (int c = 0; c < timer_pin_pkg::NCH; c++)
    begin
      // mode write: refused moves keep the mode and flag it
      if (wr_in && addr_in == timer_pin_pkg::MODE_BASE + 6'(c))
      begin
        if (move_ok(c, s_r.mode[c], wdata_in[2:0]))
        begin
          s_nxt.mode[c] = timer_pin_pkg::mode_type'(wdata_in[2:0]);
          s_nxt.bfa[c] = wdata_in[timer_pin_pkg::BFA_BIT];
          s_nxt.bfb[c] = wdata_in[timer_pin_pkg::BFB_BIT];
        end
        else
        begin
          s_nxt.merr[c] = 1'b1;
        end
      end
      if (wr_in && addr_in == timer_pin_pkg::IOH_BASE + 6'(c))
      begin
        s_nxt.ioh[c] = wdata_in[7:0];
      end
      if (wr_in && addr_in == timer_pin_pkg::IOL_BASE + 6'(c))
      begin
        s_nxt.iol[c] = wdata_in[7:0];
      end

      for (int p = 0; p < 4; p++)
      begin
        idx = c * 4 + p;
        // a/b nibbles in the high byte, c/d in the low byte
        if (p < 2)
        begin
          nib = wdata_in[4*p +: 4];
          io_wr = wr_in && addr_in == timer_pin_pkg::IOH_BASE + 6'(c);
        end
        else
        begin
          nib = wdata_in[4*(p-2) +: 4];
          io_wr = wr_in && addr_in == timer_pin_pkg::IOL_BASE + 6'(c);
        end
        // io init needs the pin enabled first
        if (io_wr && nib[1:0] != 2'h0 && moe_mask[idx] &&
            init_ok(s_r.mode[c], s_r.bfa[c], s_r.bfb[c], p))
        begin
          s_nxt.lvl[idx] = nib[timer_pin_pkg::IO_LVL];
        end
        // compl/rsync: level from phase selects, only while enabled
        // and counting; a halted hi-z pin keeps its stale level
        if ((s_nxt.mode[c] == timer_pin_pkg::MODE_COMPL ||
             s_nxt.mode[c] == timer_pin_pkg::MODE_RSYNC) &&
            moe_mask[idx] && s_nxt.cst[c])
        begin
          if (timer_pin_pkg::POS_MASK[idx])
          begin
            s_nxt.lvl[idx] = s_nxt.ols[timer_pin_pkg::POSITIVE_PHASE_LEVEL_SELECT_BIT];
          end
          else if (timer_pin_pkg::NEG_MASK[idx])
          begin
            s_nxt.lvl[idx] = s_nxt.ols[timer_pin_pkg::NEGATIVE_PHASE_LEVEL_SELECT_BIT];
          end
        end
      end
    end

    // standby forces every level low
    if (s_nxt.stby)
    begin
      s_nxt.lvl = '0;
    end

    // capture: two captures in one cycle lose the joined value
    if (s_r.casc)
    begin
      if (capture_in[0] && capture_in[1])
      begin
        s_nxt.col = 1'b1;
      end
      else if (capture_in[0])
      begin
        s_nxt.cap = {ch2_count_in, ch1_count_in};
      end
    end
    else
    begin
      if (capture_in[0])
      begin
        s_nxt.cap[15:0] = ch1_count_in;
      end
      if (capture_in[1])
      begin
        s_nxt.cap[31:16] = ch2_count_in;
      end
    end

    // pins follow the next level, so a write shows at the taking edge
    for (int i = 0; i < timer_pin_pkg::NPIN; i++)
    begin
      if (s_nxt.stby)
      begin
        s_nxt.pins.level[i] = 1'b0;
        s_nxt.pins.oe[i] = s_nxt.pfs[i] || s_nxt.pdir[i];
      end
      else if (s_nxt.pfs[i])
      begin
        // timer function shows its present level at once
        s_nxt.pins.level[i] = s_nxt.lvl[i];
        s_nxt.pins.oe[i] = moe_mask[i] &&
          !(s_nxt.cut && timer_pin_pkg::BIG_MASK[i]);
      end
      else
      begin
        // plain port output, used to cut the timer off
        s_nxt.pins.level[i] = s_nxt.pdat[i];
        s_nxt.pins.oe[i] = s_nxt.pdir[i];
      end
    end

    // read mux, unmapped offsets read zero
    if (rd_in)
    begin
      for (int c = 0; c < timer_pin_pkg::NCH; c++)
      begin
        if (addr_in == timer_pin_pkg::MODE_BASE + 6'(c))
        begin
          s_nxt.rdata = {26'h0, s_r.bfb[c], s_r.bfa[c], 1'b0, s_r.mode[c]};
        end
        if (addr_in == timer_pin_pkg::IOH_BASE + 6'(c))
        begin
          s_nxt.rdata = {24'h0, s_r.ioh[c]};
        end
        if (addr_in == timer_pin_pkg::IOL_BASE + 6'(c))
        begin
          s_nxt.rdata = {24'h0, s_r.iol[c]};
        end
      end
      case (addr_in)
        timer_pin_pkg::OUTCTL: s_nxt.rdata = {30'h0, s_r.ols};
        timer_pin_pkg::MOE:    s_nxt.rdata = {26'h0, s_r.moe};
        timer_pin_pkg::CSTART: s_nxt.rdata = {27'h0, s_r.cst};
        timer_pin_pkg::PFSEL:  s_nxt.rdata = {12'h0, s_r.pfs};
        timer_pin_pkg::PDATA:  s_nxt.rdata = {12'h0, s_r.pdat};
        timer_pin_pkg::PDIR:   s_nxt.rdata = {12'h0, s_r.pdir};
        timer_pin_pkg::SYSCTL: s_nxt.rdata = {30'h0, s_r.casc, s_r.stby};
        timer_pin_pkg::STATUS:
          s_nxt.rdata = {20'h0, s_r.col, s_r.cut, s_r.irq, s_r.merr};
        timer_pin_pkg::LEVEL:  s_nxt.rdata = {12'h0, s_r.lvl};
        timer_pin_pkg::CAPT:   s_nxt.rdata = s_r.cap;
        default: ; // channel offsets handled above
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // synchronous reset: all zero gives normal mode, pins low, hi-z
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign rdata_out     = s_r.rdata;
  assign irq_req_out   = s_r.irq;
  assign pin_level_out = s_r.pins.level;
  assign pin_oe_out    = s_r.pins.oe;

endmodule

// ### rtl/timer_pin_pkg.sv
// Purpose: constants and types for the timer output pin logic
// Assumes: five channels of four pins each (a, b, c, d)
// Notes:   offsets are word indices on the plain register port
package timer_pin_pkg;
  localparam int NCH  = 5;  // timer channels
  localparam int NPIN = 20; // four pins per channel
  localparam int AW   = 6;  // register address width
  localparam int DW   = 32; // register data width
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [AW-1:0] MODE_BASE = 6'h00; // per channel mode
  localparam logic [AW-1:0] IOH_BASE  = 6'h08; // io control, pins a/b
  localparam logic [AW-1:0] IOL_BASE  = 6'h10; // io control, pins c/d
  localparam logic [AW-1:0] OUTCTL    = 6'h18; // output control
  localparam logic [AW-1:0] MOE       = 6'h19; // output master enable
  localparam logic [AW-1:0] CSTART    = 6'h1A; // count start
  localparam logic [AW-1:0] PFSEL     = 6'h1B; // pin function select
  localparam logic [AW-1:0] PDATA     = 6'h1C; // plain port data
  localparam logic [AW-1:0] PDIR      = 6'h1D; // plain port drive
  localparam logic [AW-1:0] SYSCTL    = 6'h1E; // standby and cascade
  localparam logic [AW-1:0] STATUS    = 6'h1F; // sticky flags, w1c
  localparam logic [AW-1:0] LEVEL     = 6'h20; // pin levels, read only
  localparam logic [AW-1:0] CAPT      = 6'h21; // cascade capture
  // ****************************************
  // field positions
  // ****************************************
  localparam int BFA_BIT  = 4;  // mode reg: c buffers a
  localparam int BFB_BIT  = 5;  // mode reg: d buffers b
  localparam int IO_LVL   = 2;  // io nibble: initial level
  localparam int POSITIVE_PHASE_LEVEL_SELECT_BIT = 0;  // positive phase level
  localparam int NEGATIVE_PHASE_LEVEL_SELECT_BIT = 1;  // negative phase level
  localparam int STBY_BIT = 0;  // module standby
  localparam int CASC_BIT = 1;  // channels 1/2 cascaded
  localparam int ST_IRQ   = 5;  // status: pending requests
  localparam int ST_CUT   = 10; // status: hardware cutoff level
  localparam int ST_COL   = 11; // status: capture collision
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  localparam int CYC_PIN = PIN_A; // cycle register pin in mode two
  // master enable bit k steers pin MOE_PIN[k]: 3b,3d,4a,4c,4b,4d
  localparam int MOE_PIN [6] = '{13, 15, 16, 18, 17, 19};
  localparam logic [NPIN-1:0] POS_MASK = 20'h32000; // 3b 4a 4b
  localparam logic [NPIN-1:0] NEG_MASK = 20'hC8000; // 3d 4c 4d
  localparam logic [NPIN-1:0] BIG_MASK = 20'hFA000; // large current
  localparam logic [NPIN-1:0] ALL_PINS = 20'hFFFFF;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PULSE1 = 3'h1, // pulse_mode_one
    MODE_PULSE2 = 3'h2, // pulse_mode_two
    MODE_PHASE  = 3'h3, // phase counting 1-4
    MODE_COMPL  = 3'h4, // complementary_pulse_mode
    MODE_RSYNC  = 3'h5  // reset_sync_pulse_mode
  } mode_type;
  // pin drive carrier
  typedef struct packed {
    logic [NPIN-1:0] level;
    logic [NPIN-1:0] oe;
  } pin_drive_type;
  // whole state of the block
  typedef struct packed {
    mode_type [NCH-1:0]   mode;
    logic [NCH-1:0]       bfa;
    logic [NCH-1:0]       bfb;
    logic [NCH-1:0][7:0]  ioh;
    logic [NCH-1:0][7:0]  iol;
    logic [1:0]           ols;
    logic [5:0]           moe;
    logic [NCH-1:0]       cst;
    logic [NPIN-1:0]      pfs;
    logic [NPIN-1:0]      pdat;
    logic [NPIN-1:0]      pdir;
    logic                 stby;
    logic                 casc;
    logic [NCH-1:0]       merr;
    logic [NCH-1:0]       irq;
    logic [2:0]           sync;
    logic                 cut;
    logic                 col;
    logic [NPIN-1:0]      lvl;
    logic [DW-1:0]        cap;
    logic [DW-1:0]        rdata;
    pin_drive_type        pins;
  } state_type;
endpackage

// ### sim/pin_init_checker_sva.sv
// Purpose: port checker for the timer pin init block
// Assumes: one clock domain, synchronous active low reset
// Notes:   shadows the port, select and standby registers
module pin_init_checker
(
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic [5:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic [4:0]  irq_event_in,
  input wire logic        hw_cutoff_in,
  input wire logic [4:0]  irq_req_out,
  input wire logic [19:0] pin_level_out,
  input wire logic [19:0] pin_oe_out
);
  // ****************************************
  // register shadows
  // ****************************************
  logic        stby_r; // standby bit in force
  logic [19:0] pfs_r;  // timer function per pin
  logic [19:0] pdat_r; // plain port data
  logic [19:0] pdir_r; // plain port drive
  // follow writes so pin relations need no body access
  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      stby_r <= 1'b0;
      pfs_r  <= '0;
      pdat_r <= '0;
      pdir_r <= '0;
    end
    else if (wr_in)
    begin
      if (addr_in == timer_pin_pkg::SYSCTL) stby_r <= wdata_in[0];
      if (addr_in == timer_pin_pkg::PFSEL) pfs_r <= wdata_in[19:0];
      if (addr_in == timer_pin_pkg::PDATA) pdat_r <= wdata_in[19:0];
      if (addr_in == timer_pin_pkg::PDIR) pdir_r <= wdata_in[19:0];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking dck @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  // cutoff held long enough to cross the three-flop sync
  sequence cut_held;
    hw_cutoff_in [*7];
  endsequence
  // status clear attempted while in standby
  sequence stby_clear;
    stby_r && wr_in && addr_in == timer_pin_pkg::STATUS;
  endsequence
  reset_low_a: assert property (disable iff (1'b0) !rstn_in
    |=> pin_level_out == '0 && pin_oe_out == '0) else $error("reset pins");
  stby_low_a: assert property (stby_r |-> pin_level_out == '0)
    else $error("standby level not low");
  cut_big_a: assert property (cut_held
    |-> (pin_oe_out & timer_pin_pkg::BIG_MASK) == '0)
    else $error("large pin still driven under cutoff");
  port_level_a: assert property (!stby_r
    |-> ((pin_level_out ^ pdat_r) & ~pfs_r) == '0)
    else $error("port pin level differs from port data");
  port_drive_a: assert property (((pin_oe_out ^ pdir_r) & ~pfs_r) == '0)
    else $error("port pin drive differs from port direction");
  pin_cause_a: assert property ($changed(pin_level_out) && $past(rstn_in)
    |-> $past(wr_in)) else $error("pin level moved without a write");
  irq_set_a: assert property (irq_event_in != '0
    |=> (irq_req_out & $past(irq_event_in)) == $past(irq_event_in))
    else $error("event not latched");
  stby_keep_a: assert property (stby_clear
    |=> (irq_req_out & $past(irq_req_out)) == $past(irq_req_out))
    else $error("request cleared in standby");
endmodule

// ### sim/power_stage_model.sv
// Purpose: gate-driver stage hanging on the timer pins
// Assumes: every gate input carries a pull-down resistor
// Notes:   a released pin reads low, never its last value
module power_stage_model
(
  input  wire logic [19:0] level_in, // pin level from block
  input  wire logic [19:0] oe_in,    // pin drive enable
  output logic      [19:0] gate_out  // level the stage sees
);
  // ****************************************
  // wire resolution
  // ****************************************
  // undriven wires fall to the pull-down, so hi-z reads low
  assign gate_out = level_in & oe_in;
endmodule

// ### sim/tb_timer_output_pin_init.sv
// Purpose: register-driven bench for the timer pin init block
// Assumes: read data stands only in the cycle after the strobe
// Notes:   expected levels are tracked by hand from each write
module tb_timer_output_pin_init;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic        mclk_in      = 1'b0; // 100 MHz
  logic        rstn_in      = 1'b0; // sync reset
  logic [5:0]  addr_in      = '0;
  logic [31:0] wdata_in     = '0;
  logic        wr_in        = 1'b0;
  logic        rd_in        = 1'b0;
  logic [4:0]  irq_event_in = '0;
  logic [1:0]  capture_in   = '0;
  logic [15:0] ch1_count_in = '0;
  logic [15:0] ch2_count_in = '0;
  logic        hw_cutoff_in = 1'b0;
  logic [31:0] rdata_out;
  logic [4:0]  irq_req_out;
  logic [19:0] pin_level_out;
  logic [19:0] pin_oe_out;
  logic [19:0] gate;               // what the stage sees
  logic [19:0] lv;                 // expected timer levels
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cycles       = 0;   // hang guard
  timer_output_pin_init uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .irq_event_in(irq_event_in), .capture_in(capture_in),
    .ch1_count_in(ch1_count_in), .ch2_count_in(ch2_count_in),
    .hw_cutoff_in(hw_cutoff_in), .rdata_out(rdata_out),
    .irq_req_out(irq_req_out), .pin_level_out(pin_level_out),
    .pin_oe_out(pin_oe_out));
  power_stage_model stage (.level_in(pin_level_out), .oe_in(pin_oe_out),
    .gate_out(gate));
  always #5 mclk_in = ~mclk_in;
  // a run of ~400 cycles; far past that means a hang
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe; pins settle at the taking edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  // read and compare the masked word in its one valid cycle
  task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out & m, e);
  endtask
  // the four io control words of channels 3 and 4
  task automatic io34(input logic [31:0] d);
    for (int r = 0; r < 4; r++)
      wr((r[0] ? timer_pin_pkg::IOL_BASE : timer_pin_pkg::IOH_BASE)
         + 6'(3 + r / 2), d);
  endtask
  // which modes a channel may take
  function automatic logic ok(input int c, input int m);
    return m < 2 || (m == 2 && c < 3) || (m == 3 && c inside {1, 2})
           || (m inside {4, 5} && c > 2);
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk(32'(pin_level_out | pin_oe_out), 32'h0);
    for (int c = 0; c < 5; c++)
      rdc(timer_pin_pkg::MODE_BASE + 6'(c), 32'h0);
    rdc(6'h3F, 32'h0); // unmapped hole reads zero
    // normal mode init, ch3/4 enabled first
    wr(timer_pin_pkg::MOE, 32'h3F);
    wr(timer_pin_pkg::IOH_BASE, 32'h05);
    wr(timer_pin_pkg::IOH_BASE + 6'h3, 32'h55);
    lv = 20'h03001;
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    // pulse one skips pin b, pulse two skips cycle pin a
    wr(timer_pin_pkg::MODE_BASE + 6'h1, 32'h1);
    wr(timer_pin_pkg::IOH_BASE + 6'h1, 32'h55);
    wr(timer_pin_pkg::MODE_BASE + 6'h2, 32'h2);
    wr(timer_pin_pkg::IOH_BASE + 6'h2, 32'h55);
    lv = lv | 20'h00210;
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    // buffer pins stay put until buffer mode is left
    wr(timer_pin_pkg::MODE_BASE, 32'h10);
    wr(timer_pin_pkg::IOL_BASE, 32'h05);
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    wr(timer_pin_pkg::MODE_BASE, 32'h0);
    wr(timer_pin_pkg::IOL_BASE, 32'h05);
    lv = lv | 20'h00004;
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    wr(timer_pin_pkg::MODE_BASE + 6'h4, 32'h21);
    wr(timer_pin_pkg::IOL_BASE + 6'h4, 32'h55);
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    // select timer output only after init
    wr(timer_pin_pkg::PFSEL, 32'h1);
    chk(32'(gate), 32'h1);
    // every code on every channel, back to normal each time
    for (int c = 0; c < 5; c++)
      for (int m = 0; m < 8; m++)
      begin
        wr(timer_pin_pkg::MODE_BASE + 6'(c), 32'(m));
        rdc(timer_pin_pkg::MODE_BASE + 6'(c), ok(c, m) ? 32'(m) : 32'h0);
        wr(timer_pin_pkg::MODE_BASE + 6'(c), 32'h0);
      end
    rdc(timer_pin_pkg::STATUS, 32'h1F, 32'h1F);
    // force ch3/4 low, clear io, then ordered entry
    io34(32'h11);
    lv = lv & 20'h00FFF;
    rdc(timer_pin_pkg::LEVEL, 32'(lv));
    io34(32'h00);
    wr(timer_pin_pkg::MOE, 32'h0);
    wr(timer_pin_pkg::OUTCTL, 32'h1);
    wr(timer_pin_pkg::MODE_BASE + 6'h3, 32'h4);
    wr(timer_pin_pkg::MODE_BASE + 6'h4, 32'h5);
    wr(timer_pin_pkg::MOE, 32'h3F);
    wr(timer_pin_pkg::CSTART, 32'h18);
    rdc(timer_pin_pkg::LEVEL, 32'(timer_pin_pkg::POS_MASK),
        32'(timer_pin_pkg::BIG_MASK));
    wr(timer_pin_pkg::OUTCTL, 32'h2);
    rdc(timer_pin_pkg::LEVEL, 32'(timer_pin_pkg::NEG_MASK),
        32'(timer_pin_pkg::BIG_MASK));
    // standby pulls every level low
    wr(timer_pin_pkg::PFSEL, 32'(timer_pin_pkg::ALL_PINS));
    wr(timer_pin_pkg::SYSCTL, 32'h1);
    chk(32'(pin_level_out), 32'h0);
    wr(timer_pin_pkg::SYSCTL, 32'h0);
    // hardware cutoff floats the large pins, then lets go
    @(posedge mclk_in);
    hw_cutoff_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    chk(32'(pin_oe_out & timer_pin_pkg::BIG_MASK), 32'h0);
    rdc(timer_pin_pkg::STATUS, 32'h400, 32'h400);
    @(posedge mclk_in);
    hw_cutoff_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    #1;
    chk(32'(pin_oe_out & timer_pin_pkg::BIG_MASK),
        32'(timer_pin_pkg::BIG_MASK));
    // software cut: port drives the inactive high level
    wr(timer_pin_pkg::PDATA, 32'(timer_pin_pkg::ALL_PINS));
    wr(timer_pin_pkg::PDIR, 32'(timer_pin_pkg::ALL_PINS));
    wr(timer_pin_pkg::PFSEL, 32'h0);
    chk(32'(gate), 32'(timer_pin_pkg::ALL_PINS));
    wr(timer_pin_pkg::CSTART, 32'h0);
    // pending request survives a clear in standby
    @(posedge mclk_in);
    irq_event_in <= 5'h01;
    @(posedge mclk_in);
    irq_event_in <= 5'h00;
    wr(timer_pin_pkg::SYSCTL, 32'h1);
    wr(timer_pin_pkg::STATUS, 32'h20);
    chk(32'(irq_req_out), 32'h1);
    wr(timer_pin_pkg::SYSCTL, 32'h0);
    wr(timer_pin_pkg::STATUS, 32'h20);
    chk(32'(irq_req_out), 32'h0);
    // cascade: lone capture joins, simultaneous one is lost
    wr(timer_pin_pkg::SYSCTL, 32'h2);
    @(posedge mclk_in);
    ch1_count_in <= 16'h1234;
    ch2_count_in <= 16'hABCD;
    capture_in   <= 2'h1;
    @(posedge mclk_in);
    ch1_count_in <= 16'h5555;
    capture_in   <= 2'h3;
    @(posedge mclk_in);
    capture_in <= 2'h0;
    rdc(timer_pin_pkg::CAPT, 32'hABCD1234);
    rdc(timer_pin_pkg::STATUS, 32'h800, 32'h800);
    // mid-run reset: pins drop at once, modes back to normal
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(32'(pin_level_out | pin_oe_out), 32'h0);
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    rdc(timer_pin_pkg::MODE_BASE + 6'h3, 32'h0);
    // without cascade both halves update on a joint capture
    @(posedge mclk_in);
    capture_in <= 2'h3;
    @(posedge mclk_in);
    capture_in <= 2'h0;
    rdc(timer_pin_pkg::CAPT, 32'hABCD5555);
    close_out();
  end
endmodule
bind timer_output_pin_init pin_init_checker sva (.mclk_in(mclk_in),
  .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .irq_event_in(irq_event_in), .hw_cutoff_in(hw_cutoff_in),
  .irq_req_out(irq_req_out), .pin_level_out(pin_level_out),
  .pin_oe_out(pin_oe_out));
